// *** logic/lcd_ctrl_pkg.sv ***
// Constants and types shared by the LCD driver control block.
package lcd_ctrl_pkg;
  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_POWER_DUTY = 16'hFF60;
  localparam logic [15:0] IDX_ALL_ON_OFF = 16'hFF61;
  localparam logic [15:0] IDX_CONTRAST = 16'hFF62;
  localparam logic [15:0] IDX_DISP_BASE = 16'hF000;
  localparam int DISP_WORDS = 160;
  localparam int ADDR_W = 18;
  // ---------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------
  localparam int POS_POWER = 0;
  localparam int POS_STATIC = 1;
  localparam int POS_DUTY_LO = 2;
  localparam int POS_DUTY_HI = 3;
  localparam int POS_LIT = 1;
  localparam int POS_DARK = 2;
  localparam logic [3:0] RST_POWER_DUTY = 4'h0;
  localparam logic [3:0] RST_ALL_ON_OFF = 4'h4;
  localparam logic [3:0] RST_CONTRAST = 4'h0;
  // ---------------------------------------------------------------
  // Scan geometry and timing.
  // ---------------------------------------------------------------
  localparam int NUM_COMMONS = 8;
  localparam int ROW_WORDS = 20;
  localparam int NUM_SEGS = 4 * ROW_WORDS;
  localparam int CLK_HZ = 40_000_000;
  localparam int STEP_HZ = 4096;
  localparam int STEP_CYCLES = CLK_HZ / STEP_HZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic static_sel;
    logic [1:0] duty;
    logic all_lit;
    logic all_dark;
    logic [3:0] contrast;
  } lcd_cfg_t;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } chan_state_t;
endpackage

// *** logic/lcd_driver_control_regs.sv ***
// LCD driver control registers, display memory and common/segment scan.
//
// How it works
// - Power bit one enables drive; reads back.
// - Power bit zero forces commons and non-DC segments low.
// - Power control leaves DC segment outputs alone.
// - Duty field picks 8, 5 or 4 commons.
// - Drive-method bit one selects static drive.
// - All-lit bit lights every non-DC segment, memory kept.
// - All-dark bit blanks every non-DC segment, memory kept.
// - All-lit wins over all-dark.
// - All-dark bit resets to one.
// - Power, duty, static, all-lit reset to zero.
// - Contrast code gives sixteen levels, light to dark.
// - Contrast code resets to zero.
// - External supply makes contrast code ineffective.
// - Display memory: 160 four-bit words at F000H.
// - Unused all-on/off bits read zero.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lcd_driver_control_regs
  import lcd_ctrl_pkg::*;
#(
  parameter int STEP_DIV = STEP_CYCLES,
  parameter bit EXT_SUPPLY = 1'b0,
  parameter logic [NUM_SEGS-1:0] DC_SEG_MASK = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // LCD side
  output logic lcd_power_on,
  output logic [3:0] contrast_code,
  output logic [NUM_COMMONS-1:0] common_output,
  output logic [NUM_SEGS-1:0] segment_output
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  lcd_cfg_t cfg_reg, cfg_next;
  lcd_cfg_t cfg_sh_reg, cfg_sh_next;
  logic [3:0] mem [DISP_WORDS];
  chan_state_t wst_reg, wst_next, rst_reg, rst_next;
  logic awready_reg, awready_next, bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] widx, ridx;
  logic wr_fire, rd_fire, wr_mem, wr_hit;
  logic [7:0] wmem_idx, rmem_idx;
  assign widx = awaddr[ADDR_W-1:2];
  assign ridx = araddr[ADDR_W-1:2];
  assign wr_fire = awvalid && awready_reg && wvalid;
  assign rd_fire = arvalid && arready_reg;
  assign wmem_idx = 8'(widx - IDX_DISP_BASE);
  assign rmem_idx = 8'(ridx - IDX_DISP_BASE);
  assign wr_mem = widx >= IDX_DISP_BASE &&
                  widx < IDX_DISP_BASE + 16'(DISP_WORDS);
  assign wr_hit = wr_mem || widx == IDX_POWER_DUTY ||
                  widx == IDX_ALL_ON_OFF || widx == IDX_CONTRAST;
  // ---------------------------------------------------------------
  // Write channel: address and data are taken together.
  // ---------------------------------------------------------------
  always_comb begin
    wst_next = wst_reg;
    awready_next = 1'b0;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    cfg_next = cfg_reg;
    case (wst_reg)
      CH_IDLE: begin
        if (wr_fire) begin
          wst_next = CH_RESP;
          bvalid_next = 1'b1;
          bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
          if (wstrb[0] && widx == IDX_POWER_DUTY) begin
            cfg_next.power_on = wdata[POS_POWER];
            cfg_next.static_sel = wdata[POS_STATIC];
            cfg_next.duty = {wdata[POS_DUTY_HI], wdata[POS_DUTY_LO]};
          end
          if (wstrb[0] && widx == IDX_ALL_ON_OFF) begin
            cfg_next.all_lit = wdata[POS_LIT];
            cfg_next.all_dark = wdata[POS_DARK];
          end
          if (wstrb[0] && widx == IDX_CONTRAST) begin
            cfg_next.contrast = wdata[3:0];
          end
        end else if (awvalid && wvalid && !awready_reg) begin
          awready_next = 1'b1;
        end
      end
      CH_RESP: begin
        if (bready) begin
          wst_next = CH_IDLE;
          bvalid_next = 1'b0;
        end
      end
      default: wst_next = CH_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg <= CH_IDLE;
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      cfg_reg <= {RST_POWER_DUTY[POS_POWER], RST_POWER_DUTY[POS_STATIC],
                  RST_POWER_DUTY[POS_DUTY_HI], RST_POWER_DUTY[POS_DUTY_LO],
                  RST_ALL_ON_OFF[POS_LIT], RST_ALL_ON_OFF[POS_DARK],
                  RST_CONTRAST};
    end else begin
      wst_reg <= wst_next;
      awready_reg <= awready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      cfg_reg <= cfg_next;
    end
  end
  // Display memory has no reset, so its contents start undefined.
  always_ff @(posedge aclk) begin
    if (wr_fire && wst_reg == CH_IDLE && wr_mem && wstrb[0]) begin
      mem[wmem_idx] <= wdata[3:0];
    end
  end
  // ---------------------------------------------------------------
  // Read channel.
  // ---------------------------------------------------------------
  always_comb begin
    rst_next = rst_reg;
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    case (rst_reg)
      CH_IDLE: begin
        if (rd_fire) begin
          rst_next = CH_RESP;
          rvalid_next = 1'b1;
          rresp_next = RESP_OKAY;
          rdata_next = '0;
          if (ridx == IDX_POWER_DUTY) begin
            rdata_next[POS_POWER] = cfg_reg.power_on;
            rdata_next[POS_STATIC] = cfg_reg.static_sel;
            rdata_next[POS_DUTY_LO] = cfg_reg.duty[0];
            rdata_next[POS_DUTY_HI] = cfg_reg.duty[1];
          end else if (ridx == IDX_ALL_ON_OFF) begin
            rdata_next[POS_LIT] = cfg_reg.all_lit;
            rdata_next[POS_DARK] = cfg_reg.all_dark;
          end else if (ridx == IDX_CONTRAST) begin
            rdata_next[3:0] = cfg_reg.contrast;
          end else if (ridx >= IDX_DISP_BASE &&
                       ridx < IDX_DISP_BASE + 16'(DISP_WORDS)) begin
            rdata_next[3:0] = mem[rmem_idx];
          end else begin
            rresp_next = RESP_SLVERR;
          end
        end else if (arvalid && !arready_reg) begin
          arready_next = 1'b1;
        end
      end
      CH_RESP: begin
        if (rready) begin
          rst_next = CH_IDLE;
          rvalid_next = 1'b0;
        end
      end
      default: rst_next = CH_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_reg <= CH_IDLE;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rst_reg <= rst_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
  assign awready = awready_reg;
  assign wready = awready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  // ---------------------------------------------------------------
  // Common scan and frame-aligned settings.
  // ---------------------------------------------------------------
  // Settings are copied into a shadow only at a frame boundary, so a
  // duty change never leaves a frame with a torn common sequence.
  logic [31:0] div_reg, div_next;
  logic [2:0] row_reg, row_next;
  logic [3:0] rows;
  logic step_en, frame_end;
  logic [NUM_SEGS-1:0] row_bits, seg_next, dc_bits;
  logic [NUM_COMMONS-1:0] com_next;
  always_comb begin
    rows = 4'h4;
    if (cfg_sh_reg.static_sel) begin
      rows = 4'h1;
    end else if (cfg_sh_reg.duty[1]) begin
      rows = 4'h8;
    end else if (cfg_sh_reg.duty[0]) begin
      rows = 4'h5;
    end
  end
  assign step_en = div_reg == 32'(STEP_DIV - 1);
  assign frame_end = step_en && {1'b0, row_reg} == rows - 4'h1;
  always_comb begin
    div_next = step_en ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    row_next = row_reg;
    cfg_sh_next = cfg_sh_reg;
    if (frame_end) begin
      row_next = 3'h0;
      cfg_sh_next = cfg_reg;
    end else if (step_en) begin
      row_next = row_reg + 3'h1;
    end
  end
  genvar g;
  generate
    for (g = 0; g < ROW_WORDS; g++) begin : g_row
      assign row_bits[4*g +: 4] = mem[ROW_WORDS * row_reg + g];
      assign dc_bits[4*g +: 4] = mem[g];
    end
  endgenerate
  always_comb begin
    com_next = '0;
    com_next[row_reg] = cfg_sh_reg.power_on;
    if (!cfg_sh_reg.power_on) begin
      seg_next = '0;
    end else if (cfg_sh_reg.all_lit) begin
      seg_next = '1;
    end else if (cfg_sh_reg.all_dark) begin
      seg_next = '0;
    end else begin
      seg_next = row_bits;
    end
    // DC pins carry their own level whatever the panel controls say.
    seg_next = (seg_next & ~DC_SEG_MASK) | (dc_bits & DC_SEG_MASK);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 32'h0000_0000;
      row_reg <= 3'h0;
      cfg_sh_reg <= {RST_POWER_DUTY[POS_POWER], RST_POWER_DUTY[POS_STATIC],
                     RST_POWER_DUTY[POS_DUTY_HI], RST_POWER_DUTY[POS_DUTY_LO],
                     RST_ALL_ON_OFF[POS_LIT], RST_ALL_ON_OFF[POS_DARK],
                     RST_CONTRAST};
      lcd_power_on <= 1'b0;
      contrast_code <= 4'h0;
      common_output <= '0;
      segment_output <= '0;
    end else begin
      div_reg <= div_next;
      row_reg <= row_next;
      cfg_sh_reg <= cfg_sh_next;
      lcd_power_on <= cfg_sh_reg.power_on;
      contrast_code <= EXT_SUPPLY ? 4'h0 : cfg_sh_reg.contrast;
      common_output <= com_next;
      segment_output <= seg_next;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_frame_end;
    frame_end;
  endsequence
  property p_reset_dark;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> cfg_reg.all_dark && !cfg_reg.all_lit;
  endproperty
  a_reset_dark: assert property (p_reset_dark)
    else $error("all-dark not set after reset");
  property p_reset_zero;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> !cfg_reg.power_on && cfg_reg.duty == 2'h0 &&
        !cfg_reg.static_sel && cfg_reg.contrast == 4'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("control fields not cleared by reset");
  property p_power_off;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_sh_reg.power_on ##1 !$past(cfg_sh_reg.power_on) |->
        common_output == '0 && (segment_output & ~DC_SEG_MASK) == '0;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("drive not grounded with power off");
  property p_power_on;
    @(posedge aclk) disable iff (!aresetn)
      cfg_sh_reg.power_on && !frame_end |=>
        common_output == NUM_COMMONS'(1) << $past(row_reg);
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("common output does not follow scan row");
  property p_lit_wins;
    @(posedge aclk) disable iff (!aresetn)
      cfg_sh_reg.power_on && cfg_sh_reg.all_lit && !frame_end |=>
        (segment_output | DC_SEG_MASK) == '1;
  endproperty
  a_lit_wins: assert property (p_lit_wins)
    else $error("segments not all lit");
  property p_dark;
    @(posedge aclk) disable iff (!aresetn)
      cfg_sh_reg.all_dark && !cfg_sh_reg.all_lit && !frame_end |=>
        (segment_output & ~DC_SEG_MASK) == '0;
  endproperty
  a_dark: assert property (p_dark)
    else $error("segments not all dark");
  property p_row_range;
    @(posedge aclk) disable iff (!aresetn)
      {1'b0, row_reg} < rows && (!cfg_sh_reg.static_sel || row_reg == 3'h0);
  endproperty
  a_row_range: assert property (p_row_range)
    else $error("scan row beyond selected duty");
  property p_frame_load;
    @(posedge aclk) disable iff (!aresetn)
      s_frame_end |=> cfg_sh_reg == $past(cfg_reg) && row_reg == 3'h0
        ##1 lcd_power_on == cfg_sh_reg.power_on;
  endproperty
  a_frame_load: assert property (p_frame_load)
    else $error("settings not applied at frame boundary");
  property p_contrast;
    @(posedge aclk) disable iff (!aresetn)
      ##1 contrast_code == (EXT_SUPPLY ? 4'h0 : $past(cfg_sh_reg.contrast));
  endproperty
  a_contrast: assert property (p_contrast)
    else $error("contrast code output wrong");
  property p_unused_zero;
    @(posedge aclk) disable iff (!aresetn)
      rd_fire && rst_reg == CH_IDLE && ridx == IDX_ALL_ON_OFF |=>
        rvalid && rdata[3] == 1'b0 && rdata[0] == 1'b0 &&
        rdata[POS_DARK] == $past(cfg_reg.all_dark);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused all-on/off bits not zero");
endmodule

// *** testbench/lcd_panel_model.sv ***
// Behavioural segment panel that records what each common row shows.
`timescale 1ns/1ps
module lcd_panel_model
  import lcd_ctrl_pkg::*;
(
  // Clock and record control
  input wire logic aclk,
  input wire logic clear,
  // Panel terminals
  input wire logic [NUM_COMMONS-1:0] common_output,
  input wire logic [NUM_SEGS-1:0] segment_output,
  // Recorded picture
  output logic [NUM_COMMONS-1:0] rows_seen,
  output logic [NUM_SEGS-1:0] row_segs [NUM_COMMONS]
);
  // The panel only listens, so it can never stall or disturb the scan.
  always @(posedge aclk) begin
    if (clear) begin
      rows_seen <= '0;
    end else begin
      for (int r = 0; r < NUM_COMMONS; r++) begin
        if (common_output[r] === 1'b1) begin
          rows_seen[r] <= 1'b1;
          row_segs[r] <= segment_output;
        end
      end
    end
  end
endmodule

// *** testbench/test_lcd_driver_control_regs.sv ***
// Self-checking bench for the LCD driver control registers.
`timescale 1ns/1ps
module test_lcd_driver_control_regs;
  import lcd_ctrl_pkg::*;
  localparam int DIV = 4;
  localparam logic [NUM_SEGS-1:0] DC_MASK = 80'hF;
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, clear = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, lcd_power_on;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] contrast_code, contrast_ext;
  logic [NUM_COMMONS-1:0] common_output, rows_seen;
  logic [NUM_SEGS-1:0] segment_output;
  logic [NUM_SEGS-1:0] row_segs [NUM_COMMONS];
  int mismatches = 0, n_compared = 0, cycles = 0;
  logic [3:0] codes [5] = '{4'h1, 4'h5, 4'h3, 4'hD, 4'h9};
  logic [7:0] masks [5] = '{8'h0F, 8'h1F, 8'h01, 8'hFF, 8'hFF};
  logic [3:0] forces [3] = '{4'h2, 4'h4, 4'h6};
  int modes [3] = '{1, 2, 1};

  always #12.5 aclk = ~aclk;

  lcd_driver_control_regs #(.STEP_DIV(DIV), .DC_SEG_MASK(DC_MASK)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lcd_power_on(lcd_power_on), .contrast_code(contrast_code),
    .common_output(common_output), .segment_output(segment_output));

  lcd_panel_model i_panel (.aclk(aclk), .clear(clear),
    .common_output(common_output), .segment_output(segment_output),
    .rows_seen(rows_seen), .row_segs(row_segs));

  // A copy built for an external supply must keep its contrast code muted.
  lcd_driver_control_regs #(.STEP_DIV(DIV), .EXT_SUPPLY(1'b1)) i_dut_ext (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(), .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(),
    .rresp(), .rvalid(), .rready(rready),
    .lcd_power_on(), .contrast_code(contrast_ext),
    .common_output(), .segment_output());

  // ---------------------------------------------------------------
  // Checking and closing.
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [79:0] seen, logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  function automatic logic [3:0] pat(int i);
    return 4'(i * 7 + 3);
  endfunction

  // Mode 0 shows memory, 1 all lit, 2 all dark; DC bits always word 0.
  function automatic logic [NUM_SEGS-1:0] exp_seg(int r, int mode);
    logic [NUM_SEGS-1:0] s;
    for (int w = 0; w < ROW_WORDS; w++) begin
      s[4*w +: 4] = (mode == 1) ? 4'hF : (mode == 2) ? 4'h0 :
        pat(r * ROW_WORDS + w);
    end
    s[3:0] = pat(0);
    return s;
  endfunction

  // ---------------------------------------------------------------
  // Register bus master.
  // ---------------------------------------------------------------
  task automatic wr(logic [15:0] idx, logic [3:0] d, logic [1:0] er);
    bit aw, w;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {28'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic rd(logic [15:0] idx, logic [3:0] ed, logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("rdata", rdata, {28'h0, ed});
    check("rresp", rresp, er);
  endtask

  // Lets new settings reach a frame boundary, then records for two eight-common frame times.
  task automatic settle();
    repeat (3 * DIV * NUM_COMMONS) @(posedge aclk);
    clear <= 1'b1;
    @(posedge aclk);
    clear <= 1'b0;
    repeat (2 * DIV * NUM_COMMONS) @(posedge aclk);
  endtask

  task automatic check_rows(logic [7:0] mask, int mode);
    check("rows_seen", rows_seen, mask);
    for (int r = 0; r < NUM_COMMONS; r++) begin
      if (mask[r]) check("row_segs", row_segs[r], exp_seg(r, mode));
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_POWER_DUTY, 4'h0, RESP_OKAY);
    rd(IDX_ALL_ON_OFF, 4'h4, RESP_OKAY);
    rd(IDX_CONTRAST, 4'h0, RESP_OKAY);
    check("power", lcd_power_on, 1'b0);
    check("commons", common_output, 8'h00);
    wr(IDX_ALL_ON_OFF, 4'hF, RESP_OKAY);
    rd(IDX_ALL_ON_OFF, 4'h6, RESP_OKAY);
    rd(16'hFF63, 4'h0, RESP_SLVERR);
    wr(16'hFF63, 4'hF, RESP_SLVERR);
    // Memory is undefined after reset, so it is filled before display.
    for (int i = 0; i < DISP_WORDS; i++) begin
      wr(IDX_DISP_BASE + 16'(i), pat(i), RESP_OKAY);
    end
    rd(IDX_DISP_BASE, pat(0), RESP_OKAY);
    rd(IDX_DISP_BASE + 16'd159, pat(159), RESP_OKAY);
    // Full-scale contrast is legal here: the supply is not in halver mode.
    wr(IDX_CONTRAST, 4'hF, RESP_OKAY);
    rd(IDX_CONTRAST, 4'hF, RESP_OKAY);
    wr(IDX_ALL_ON_OFF, 4'h0, RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_POWER_DUTY, codes[k], RESP_OKAY);
      rd(IDX_POWER_DUTY, codes[k], RESP_OKAY);
      settle();
      check("power", lcd_power_on, 1'b1);
      check("contrast", contrast_code, 4'hF);
      check("contrast_ext", contrast_ext, 4'h0);
      check_rows(masks[k], 0);
    end
    for (int k = 0; k < 3; k++) begin
      wr(IDX_ALL_ON_OFF, forces[k], RESP_OKAY);
      settle();
      check_rows(8'hFF, modes[k]);
    end
    wr(IDX_ALL_ON_OFF, 4'h0, RESP_OKAY);
    settle();
    check_rows(8'hFF, 0);
    wr(IDX_POWER_DUTY, 4'h8, RESP_OKAY);
    settle();
    check("power", lcd_power_on, 1'b0);
    check("commons", common_output, 8'h00);
    check("segments", segment_output, exp_seg(0, 2));
    stop_test();
  end
endmodule
